// >>> logic/sfphr_defs.vh
`ifndef SFPHR_DEFS_VH
`define SFPHR_DEFS_VH

// ==========================================================================
// Command opcodes.
// ==========================================================================
`define SFPHR_OP_RESUME_DPD  8'hAB
`define SFPHR_OP_ENTER_DPD   8'hB9
`define SFPHR_OP_ENTER_UDPD  8'h79
`define SFPHR_OP_RESET       8'hF0
`define SFPHR_OP_RESET_CONF  8'hD0
`define SFPHR_OP_WR_STAT2    8'h31
`define SFPHR_OP_WR_ENABLE   8'h06
`define SFPHR_OP_WR_DISABLE  8'h04
`define SFPHR_OP_RD_STATUS   8'h05

// ==========================================================================
// Field positions and framing.
// ==========================================================================
`define SFPHR_RESET_CMD_ENABLE_BIT_BIT       4
`define SFPHR_BIT_LAST       3'h7
`define SFPHR_BYTES_ONE      2'h1
`define SFPHR_BYTES_TWO      2'h2

// ==========================================================================
// Power states.
// ==========================================================================
`define SFPHR_ST_STBY        3'h0
`define SFPHR_ST_DPD         3'h1
`define SFPHR_ST_UDPD        3'h2
`define SFPHR_ST_DPD_IN      3'h3
`define SFPHR_ST_DPD_OUT     3'h4
`define SFPHR_ST_UDPD_IN     3'h5
`define SFPHR_ST_WAKE        3'h6
`define SFPHR_ST_SRST        3'h7

// ==========================================================================
// Timing: times in ns, clock in MHz, cycle counts derived from them.
// ==========================================================================
`define SFPHR_CLK_MHZ        40
`define SFPHR_NS_PER_US      1000
`define SFPHR_DPD_ENTRY_NS   3000
`define SFPHR_DPD_EXIT_NS    8000
`define SFPHR_UDPD_ENTRY_NS  3000
`define SFPHR_UDPD_EXIT_NS   70000
`define SFPHR_UDPD_LOW_NS    20
`define SFPHR_SRST_NS        28000
`define SFPHR_MAX1(x)        (((x) < 1) ? 1 : (x))
`define SFPHR_CYC_DN(ns)     `SFPHR_MAX1((ns) * `SFPHR_CLK_MHZ / `SFPHR_NS_PER_US)
`define SFPHR_CYC_UP(ns)     `SFPHR_MAX1(((ns) * `SFPHR_CLK_MHZ + `SFPHR_NS_PER_US - 1) / `SFPHR_NS_PER_US)

`endif

// >>> logic/sfphr_sync.v
`timescale 1ns/100ps
// ==========================================================================
// Two-stage synchroniser, one stage pair per bit.
// ==========================================================================
module sfphr_sync #(
  parameter       WIDTH     = 5,
  parameter [4:0] RESET_VAL = 5'h00
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_r;
      reg stab_r;
      // The first stage feeds only the second; nothing else reads it.
      always @(posedge clk) begin
        if (!reset_n) begin
          meta_r <= RESET_VAL[g];
          stab_r <= RESET_VAL[g];
        end else begin
          meta_r <= async_in[g];
          stab_r <= meta_r;
        end
      end
      assign sync_out[g] = stab_r;
    end
  endgenerate
endmodule

// >>> logic/sfphr_core.v
`timescale 1ns/100ps
`include "sfphr_defs.vh"

module sfphr_core #(
  parameter integer DPD_ENTRY_CYC  = `SFPHR_CYC_DN(`SFPHR_DPD_ENTRY_NS),
  parameter integer DPD_EXIT_CYC   = `SFPHR_CYC_DN(`SFPHR_DPD_EXIT_NS),
  parameter integer UDPD_ENTRY_CYC = `SFPHR_CYC_DN(`SFPHR_UDPD_ENTRY_NS),
  parameter integer UDPD_EXIT_CYC  = `SFPHR_CYC_DN(`SFPHR_UDPD_EXIT_NS),
  parameter integer UDPD_LOW_CYC   = `SFPHR_CYC_UP(`SFPHR_UDPD_LOW_NS),
  parameter integer SRST_CYC       = `SFPHR_CYC_DN(`SFPHR_SRST_NS)
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       sck,
  input  wire       cs_n,
  input  wire       si,
  input  wire       hold_n,
  input  wire       wp_n,
  input  wire       pe_busy,
  input  wire       seq_prog,
  output reg        so_out_r,
  output reg        so_oe_n_r,
  output reg  [2:0] power_state_r,
  output reg        ready_r,
  output reg        hold_active_r,
  output reg        write_protect_r,
  output reg        write_enable_latch_r,
  output reg        reset_cmd_enable_bit_r,
  output reg        pe_abort_r
);
  // ========================================================================
  // Timer load values.
  localparam [11:0] DPD_IN_LD   = DPD_ENTRY_CYC[11:0] - 12'h001;
  localparam [11:0] DPD_OUT_LD  = DPD_EXIT_CYC[11:0] - 12'h001;
  localparam [11:0] UDPD_IN_LD  = UDPD_ENTRY_CYC[11:0] - 12'h001;
  localparam [11:0] UDPD_OUT_LD = UDPD_EXIT_CYC[11:0] - 12'h001;
  localparam [11:0] UDPD_LOW_LD = UDPD_LOW_CYC[11:0] - 12'h001;
  localparam [11:0] SRST_LD     = SRST_CYC[11:0] - 12'h001;
  // ========================================================================
  // Pin synchronisation and edge detection.
  wire [4:0] pins_s;
  wire       sck_s;
  wire       cs_n_s;
  wire       si_s;
  wire       hold_n_s;
  wire       wp_n_s;
  reg        sck_d_r;
  reg        cs_n_d_r;

  sfphr_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h1C)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({wp_n, hold_n, cs_n, si, sck}),
    .sync_out (pins_s)
  );

  assign {wp_n_s, hold_n_s, cs_n_s, si_s, sck_s} = pins_s;
  // Previous samples give clock and select edges in the system domain.
  always @(posedge clk) begin
    if (!reset_n) begin
      sck_d_r  <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sck_d_r  <= sck_s;
      cs_n_d_r <= cs_n_s;
    end
  end
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;
  wire cs_fall  = ~cs_n_s & cs_n_d_r;
  wire cs_rise  = cs_n_s & ~cs_n_d_r;
  wire hold_active_nxt = cs_n_s ? 1'b0 : (sck_s ? hold_active_r : ~hold_n_s); // Lets the output float at once.
  // ========================================================================
  // Pause control.
  // Pause state only changes while the serial clock is low or on deselect, so a pause
  // request made mid high phase waits for the next low phase.
  always @(posedge clk) begin
    if (!reset_n) begin
      hold_active_r <= 1'b0;
    end else if (cs_n_s) begin
      hold_active_r <= 1'b0;
    end else if (!sck_s) begin
      hold_active_r <= ~hold_n_s;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      write_protect_r <= 1'b0;
    end else begin
      write_protect_r <= ~wp_n_s;
    end
  end
  // ========================================================================
  // Serial shifter.
  reg  [7:0] shf_r;
  reg  [2:0] bit_r;
  reg  [1:0] nbyte_r;
  reg  [7:0] op_r;
  reg  [7:0] dat_r;
  reg        ign_r;
  reg  [7:0] stat_sh_r;
  reg        stat_en_r;
  reg  [2:0] state_r;
  reg  [11:0] tmr_r;
  wire [7:0] shf_nxt   = {shf_r[6:0], si_s};
  wire       byte_done = sck_rise & ~hold_active_r & ~cs_n_s & (bit_r == `SFPHR_BIT_LAST);
  wire       aligned   = (bit_r == 3'h0);
  wire       pausing   = hold_active_r | ~hold_n_s;
  wire [7:0] stat_val  = {3'h0, reset_cmd_enable_bit_r, 2'h0, write_enable_latch_r, ~ready_r};
  // Bits are taken on rising clock edges while selected and not paused.
  always @(posedge clk) begin
    if (!reset_n) begin
      shf_r   <= 8'h00;
      bit_r   <= 3'h0;
      nbyte_r <= 2'h0;
      op_r    <= 8'h00;
      dat_r   <= 8'h00;
    end else if (cs_fall) begin
      bit_r   <= 3'h0;
      nbyte_r <= 2'h0;
    end else if (sck_rise && !cs_n_s && !hold_active_r) begin
      shf_r <= shf_nxt;
      bit_r <= bit_r + 3'h1;
      if (bit_r == `SFPHR_BIT_LAST) begin
        if (nbyte_r == 2'h0) begin
          op_r <= shf_nxt;
        end
        if (nbyte_r == `SFPHR_BYTES_ONE) begin
          dat_r <= shf_nxt;
        end
        if (nbyte_r != `SFPHR_BYTES_TWO) begin
          nbyte_r <= nbyte_r + 2'h1;
        end
      end
    end
  end
  // A frame is ignored when it starts outside standby or deep power-down,
  // or when a bit arrives while the part is still waking.
  always @(posedge clk) begin
    if (!reset_n) begin
      ign_r <= 1'b0;
    end else if (cs_fall) begin
      ign_r <= (state_r != `SFPHR_ST_STBY) && (state_r != `SFPHR_ST_DPD);
    end else if (sck_rise && !cs_n_s && state_r != `SFPHR_ST_STBY && state_r != `SFPHR_ST_DPD) begin
      ign_r <= 1'b1;
    end
  end
  // ========================================================================
  // Status read output.
  // Status bits leave on falling edges so the host samples them on rising.
  always @(posedge clk) begin
    if (!reset_n) begin
      stat_sh_r <= 8'h00;
      stat_en_r <= 1'b0;
      so_out_r  <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (cs_n_s) begin
      stat_en_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (hold_active_nxt) begin
      so_oe_n_r <= 1'b1;
    end else begin
      if (byte_done && nbyte_r == 2'h0 && shf_nxt == `SFPHR_OP_RD_STATUS &&
          state_r == `SFPHR_ST_STBY && !ign_r) begin
        stat_sh_r <= stat_val;
        stat_en_r <= 1'b1;
      end
      if (sck_fall && stat_en_r) begin
        so_out_r  <= stat_sh_r[7];
        so_oe_n_r <= 1'b0;
        stat_sh_r <= {stat_sh_r[6:0], stat_sh_r[7]};
      end
    end
  end
  // ========================================================================
  // Command decode at frame end.
  wire fr_ok   = cs_rise & ~ign_r & ~pausing & aligned;
  wire has_op  = (nbyte_r != 2'h0);
  wire has_two = (nbyte_r == `SFPHR_BYTES_TWO);
  wire in_stby = (state_r == `SFPHR_ST_STBY);
  wire do_res  = fr_ok & has_op & (state_r == `SFPHR_ST_DPD) & (op_r == `SFPHR_OP_RESUME_DPD);
  wire do_dpd  = fr_ok & has_op & in_stby & ~pe_busy & (op_r == `SFPHR_OP_ENTER_DPD);
  wire do_udpd = cs_rise & ~ign_r & ~pausing & has_op & in_stby & ~pe_busy & (op_r == `SFPHR_OP_ENTER_UDPD);
  wire do_srst = fr_ok & has_two & in_stby & reset_cmd_enable_bit_r &
                 (op_r == `SFPHR_OP_RESET) & (dat_r == `SFPHR_OP_RESET_CONF);
  wire is_ws2  = cs_rise & ~ign_r & in_stby & has_op & (op_r == `SFPHR_OP_WR_STAT2);
  wire do_wren = fr_ok & has_op & in_stby & (op_r == `SFPHR_OP_WR_ENABLE);
  wire do_wrdi = fr_ok & has_op & in_stby & (op_r == `SFPHR_OP_WR_DISABLE);
  // Status byte two and the write enable latch.
  always @(posedge clk) begin
    if (!reset_n) begin
      reset_cmd_enable_bit_r <= 1'b0;
      write_enable_latch_r   <= 1'b0;
    end else if (cs_rise && pausing && !ign_r) begin
      write_enable_latch_r <= 1'b0;
    end else if (is_ws2) begin
      if (write_enable_latch_r && has_two && aligned && !pausing) begin
        reset_cmd_enable_bit_r <= dat_r[`SFPHR_RESET_CMD_ENABLE_BIT_BIT];
      end
      write_enable_latch_r <= 1'b0;
    end else if (do_srst && !seq_prog) begin
      write_enable_latch_r <= 1'b0;
    end else if (do_wren) begin
      write_enable_latch_r <= 1'b1;
    end else if (do_wrdi) begin
      write_enable_latch_r <= 1'b0;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      pe_abort_r <= 1'b0;
    end else begin
      pe_abort_r <= do_srst;
    end
  end
  // ========================================================================
  // Power state machine.
  // One down counter times every timed state and the ultra-deep select low time; each timed state holds the
  // part not ready until the counter reaches zero.
  always @(posedge clk) begin
    if (!reset_n) begin
      state_r <= `SFPHR_ST_STBY;
      tmr_r   <= 12'h000;
    end else begin
      case (state_r)
        `SFPHR_ST_STBY: begin
          if (do_dpd) begin
            state_r <= `SFPHR_ST_DPD_IN;
            tmr_r   <= DPD_IN_LD;
          end else if (do_udpd) begin
            state_r <= `SFPHR_ST_UDPD_IN;
            tmr_r   <= UDPD_IN_LD;
          end else if (do_srst) begin
            state_r <= `SFPHR_ST_SRST;
            tmr_r   <= SRST_LD;
          end
        end
        `SFPHR_ST_DPD: begin
          if (do_res) begin
            state_r <= `SFPHR_ST_DPD_OUT;
            tmr_r   <= DPD_OUT_LD;
          end
        end
        `SFPHR_ST_UDPD: begin
          if (cs_fall) begin
            tmr_r <= UDPD_LOW_LD;
          end else if (!cs_n_s && !cs_n_d_r) begin
            if (tmr_r == 12'h000) begin
              state_r <= `SFPHR_ST_WAKE;
              tmr_r   <= UDPD_OUT_LD;
            end else begin
              tmr_r <= tmr_r - 12'h001;
            end
          end
        end
        `SFPHR_ST_DPD_IN, `SFPHR_ST_DPD_OUT, `SFPHR_ST_UDPD_IN,
        `SFPHR_ST_WAKE, `SFPHR_ST_SRST: begin
          if (tmr_r != 12'h000) begin
            tmr_r <= tmr_r - 12'h001;
          end else if (state_r == `SFPHR_ST_DPD_IN) begin
            state_r <= `SFPHR_ST_DPD;
          end else if (state_r == `SFPHR_ST_UDPD_IN) begin
            state_r <= `SFPHR_ST_UDPD;
          end else begin
            state_r <= `SFPHR_ST_STBY;
          end
        end
        default: begin
          state_r <= `SFPHR_ST_STBY;
        end
      endcase
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      power_state_r <= `SFPHR_ST_STBY;
      ready_r       <= 1'b1;
    end else begin
      power_state_r <= state_r;
      ready_r       <= (state_r == `SFPHR_ST_STBY) & ~pe_busy;
    end
  end
endmodule

// >>> sim/sfphr_core_asserts.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checker for the power, pause and soft reset sequencer.
// ==========================================================================
module sfphr_core_asserts #(
  parameter integer SRST_CYC = 8
) (
  input wire       clk,
  input wire       reset_n,
  input wire       hold_n,
  input wire       cs_n,
  input wire       wp_n,
  input wire       pe_busy,
  input wire       so_oe_n_r,
  input wire [2:0] power_state_r,
  input wire       ready_r,
  input wire       hold_active_r,
  input wire       write_protect_r,
  input wire       reset_cmd_enable_bit_r,
  input wire       pe_abort_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // The soft reset window is counted by the core; it must not end early.
  sequence s_srst_run;
    (power_state_r == 3'h7)[*7];
  endsequence
  sequence s_abort_seen;
    pe_abort_r ##[0:1] (power_state_r == 3'h7);
  endsequence
  a_pause_floats: assert property (hold_active_r |-> so_oe_n_r)
    else $error("output driven while paused");
  a_pause_cause: assert property ($rose(hold_active_r) |-> $past(!hold_n, 2) && $past(!cs_n, 2))
    else $error("pause began without pin and select low");
  a_protect_live: assert property ($fell(wp_n) |-> ##[1:4] write_protect_r)
    else $error("protect pin not followed");
  a_abort_pulse: assert property (pe_abort_r |=> !pe_abort_r)
    else $error("abort pulse too long");
  a_abort_enabled: assert property (pe_abort_r |-> reset_cmd_enable_bit_r)
    else $error("abort without enable bit");
  a_abort_keeps_en: assert property (pe_abort_r |=> $stable(reset_cmd_enable_bit_r))
    else $error("reset changed enable bit");
  a_abort_state: assert property (pe_abort_r |-> s_abort_seen)
    else $error("abort without reset state");
  a_srst_window: assert property ($rose(power_state_r == 3'h7) |-> s_srst_run ##[1:3] (power_state_r == 3'h0))
    else $error("soft reset window wrong");
  a_udpd_deaf: assert property (power_state_r == 3'h2 |=> power_state_r inside {3'h2, 3'h6})
    else $error("ultra-deep left by a command");
  a_dpd_only_resume: assert property (power_state_r == 3'h1 |=> power_state_r inside {3'h1, 3'h4})
    else $error("deep left other than by resume");
  a_not_ready: assert property ((power_state_r != 3'h0)[*2] |-> !ready_r)
    else $error("ready outside standby");
  a_busy_no_udpd: assert property ($rose(power_state_r == 3'h5) |-> $past(!pe_busy) || $past(!pe_busy, 2))
    else $error("ultra-deep entered while busy");
endmodule

bind sfphr_core sfphr_core_asserts #(.SRST_CYC(SRST_CYC)) chk_u (
  .clk(clk), .reset_n(reset_n), .hold_n(hold_n), .cs_n(cs_n), .wp_n(wp_n), .pe_busy(pe_busy),
  .so_oe_n_r(so_oe_n_r), .power_state_r(power_state_r), .ready_r(ready_r), .hold_active_r(hold_active_r),
  .write_protect_r(write_protect_r), .reset_cmd_enable_bit_r(reset_cmd_enable_bit_r), .pe_abort_r(pe_abort_r)
);

// >>> sim/sfphr_host.sv
`timescale 1ns/100ps
// ==========================================================================
// Host model: drives the serial link with a 200 ns clock period.
// ==========================================================================
module sfphr_host (
  input  wire  clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  // The link idles with the clock parked low and select released.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // One frame; hp is the bit slot where pause is raised, rel lets it go again.
  task automatic frame(input logic [15:0] d, input int n, input int hp = -1, input bit rel = 1'b1);
    @(posedge clk);
    cs_n <= 1'b0;
    half();
    for (int i = 0; i <= n; i++) begin
      if (i == hp) begin
        hold_n <= 1'b0;
        // Clock and data keep moving so a leaky pause would corrupt the frame.
        repeat (2) begin
          half();
          sck <= 1'b1;
          si <= ~si;
          half();
          sck <= 1'b0;
        end
        hold_n <= rel;
        half();
      end
      if (i < n) begin
        si <= d[15-i];
        half();
        sck <= 1'b1;
        half();
        sck <= 1'b0;
      end
    end
    half();
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge clk);
    hold_n <= 1'b1;
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench for the power, pause and soft reset sequencer.
// ==========================================================================
module tb;
  logic       clk;
  logic       reset_n;
  logic       wp_n;
  logic       pe_busy;
  logic       seq_prog;
  wire        sck;
  wire        cs_n;
  wire        si;
  wire        hold_n;
  wire        so_out_r;
  wire        so_oe_n_r;
  wire  [2:0] power_state_r;
  wire        ready_r;
  wire        hold_active_r;
  wire        write_protect_r;
  wire        write_enable_latch_r;
  wire        reset_cmd_enable_bit_r;
  wire        pe_abort_r;
  int         err_count;
  int         total_checks;
  int         aborts;
  int         hold_cycles;
  logic [7:0] so_cap;
  logic [7:0] dpd_op [5] = '{8'hB9, 8'h05, 8'hAB, 8'hAB, 8'hAB};
  int         dpd_len [5] = '{8, 16, 5, 12, 8};
  logic [2:0] dpd_st [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h0};

  // Short timers keep the run brief; the wake window still fits a whole frame.
  // The select low time keeps its default, so the shortest wake path is exercised.
  sfphr_core #(.DPD_ENTRY_CYC(8), .DPD_EXIT_CYC(8), .UDPD_ENTRY_CYC(8), .UDPD_EXIT_CYC(200),
    .SRST_CYC(8)) dut_u (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .pe_busy(pe_busy), .seq_prog(seq_prog), .so_out_r(so_out_r), .so_oe_n_r(so_oe_n_r),
    .power_state_r(power_state_r), .ready_r(ready_r), .hold_active_r(hold_active_r),
    .write_protect_r(write_protect_r), .write_enable_latch_r(write_enable_latch_r),
    .reset_cmd_enable_bit_r(reset_cmd_enable_bit_r), .pe_abort_r(pe_abort_r));
  sfphr_host host_u (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulses are counted here so a one-cycle abort is never missed.
  always @(posedge clk) begin
    if (pe_abort_r === 1'b1)
      aborts++;
    if (hold_active_r === 1'b1)
      hold_cycles++;
  end
  // The host's view of the serial output, taken on its own rising clock edge.
  always @(posedge sck) begin
    if (!cs_n && so_oe_n_r === 1'b0)
      so_cap <= {so_cap[6:0], so_out_r};
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_state(input logic [2:0] s);
    int k;
    k = 0;
    while (power_state_r !== s && k < 400) begin
      @(posedge clk);
      k++;
    end
    check(power_state_r, s);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A hang is cut off well past the expected run of about 3600 cycles.
  initial begin
    #1000000;
    err_count++;
    wrap_up();
  end

  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    pe_busy = 1'b0;
    seq_prog = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(power_state_r, 3'h0);
    check(ready_r, 1'b1);
    $display("test power_on done");
    for (int k = 0; k < 2; k++) begin
      host_u.frame(16'h0600, 8);
      host_u.frame({8'h31, k ? 8'h10 : 8'hEF}, 16);
      check(reset_cmd_enable_bit_r, k);
      check(write_enable_latch_r, 1'b0);
      host_u.frame(16'h0600, 8);
      host_u.frame(16'hF0D0, k ? 12 : 16);
      host_u.frame(16'hF0D0, 8);
      check(aborts[2:0], 3'h0);
      check(write_enable_latch_r, 1'b1);
    end
    pe_busy <= 1'b1;
    host_u.frame(16'hF0D0, 16);
    check(aborts[2:0], 3'h1);
    wait_state(3'h0);
    check(write_enable_latch_r, 1'b0);
    check(reset_cmd_enable_bit_r, 1'b1);
    host_u.frame(16'hF0D0, 16);
    check(aborts[2:0], 3'h2);
    host_u.frame(16'h0600, 8);
    seq_prog <= 1'b1;
    host_u.frame(16'hF0D0, 16);
    wait_state(3'h0);
    check(write_enable_latch_r, 1'b1);
    seq_prog <= 1'b0;
    $display("test soft_reset done");
    pe_busy <= 1'b0;
    host_u.frame(16'h0500, 16);
    check(so_cap, 8'h12);
    for (int k = 0; k < 5; k++) begin
      host_u.frame({dpd_op[k], 8'h00}, dpd_len[k]);
      wait_state(dpd_st[k]);
    end
    check(so_cap, 8'h12);
    $display("test deep done");
    pe_busy <= 1'b1;
    host_u.frame(16'h7900, 8);
    wait_state(3'h0);
    pe_busy <= 1'b0;
    host_u.frame(16'h7900, 5);
    wait_state(3'h0);
    for (int k = 0; k < 2; k++) begin
      host_u.frame(16'h7900, 12);
      wait_state(3'h2);
      if (k == 0) begin
        host_u.frame(16'h0000, 8);
        check(power_state_r, 3'h6);
      end
      host_u.frame(16'hB900, 8);
      wait_state(3'h0);
      repeat (20) @(posedge clk);
      check(power_state_r, 3'h0);
    end
    $display("test ultra_deep done");
    host_u.frame(16'h0400, 8, 3);
    check(write_enable_latch_r, 1'b0);
    check(hold_cycles > 0, 1'b1);
    host_u.frame(16'h0600, 8, 2);
    check(write_enable_latch_r, 1'b1);
    host_u.frame(16'h0500, 8, 8, 1'b0);
    check(write_enable_latch_r, 1'b0);
    wp_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(write_protect_r, 1'b1);
    wp_n <= 1'b1;
    $display("test pause done");
    host_u.frame(16'h0600, 8);
    host_u.frame(16'h7900, 8);
    wait_state(3'h2);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(power_state_r, 3'h0);
    check(write_enable_latch_r, 1'b0);
    check(reset_cmd_enable_bit_r, 1'b0);
    $display("test power_cycle done");
    wrap_up();
  end
endmodule
